// ---- core/sps_setup_regs.sv ----
// Purpose: Secondary serial port setup words with validating handshake
// Assumes: APB3 slave, single clock, inputs synchronous to pclk
// Notes:   Decoded active settings leave on ports for the serial engine
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/100ps
`include "sps_map.svh"
module sps_setup_regs (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    output logic             autodetect,
    output logic      [4:0]  protocol_sel,
    output logic      [9:0]  rts_on_delay_ms,
    output logic      [9:0]  rts_off_delay_ms,
    output logic      [12:0] timeout_pct,
    output logic      [15:0] timeout_ms,
    output logic      [1:0]  parity_code,
    output logic             two_stop_bits,
    output logic             echo_suppress,
    output logic      [15:0] baud_rate,
    output logic      [7:0]  station_addr,
    output logic             ascii_format,
    output logic      [1:0]  flow_ctrl,
    output logic      [15:0] ascii_buffer_addr
);
    import sps_pkg::*;

    sps_state_s r;      // Registered state
    sps_state_s n;      // Next state

    // RTS delay code to milliseconds
    function automatic logic [9:0] dly_ms(input logic [2:0] c);
        case (c)
            3'h0:    dly_ms = 10'd0;
            3'h1:    dly_ms = 10'd2;
            3'h2:    dly_ms = 10'd5;
            3'h3:    dly_ms = 10'd10;
            3'h4:    dly_ms = 10'd20;
            3'h5:    dly_ms = 10'd50;
            3'h6:    dly_ms = 10'd100;
            default: dly_ms = 10'd500;
        endcase
    endfunction

    // Timeout code to percent of base
    function automatic logic [12:0] tmo_pct(input logic [2:0] c);
        case (c)
            3'h0:    tmo_pct = 13'd100;
            3'h1:    tmo_pct = 13'd120;
            3'h2:    tmo_pct = 13'd150;
            3'h3:    tmo_pct = 13'd200;
            3'h4:    tmo_pct = 13'd500;
            3'h5:    tmo_pct = 13'd1000;
            3'h6:    tmo_pct = 13'd2000;
            default: tmo_pct = 13'd5000;
        endcase
    endfunction

    // Baud code to bit rate
    function automatic logic [15:0] baud_of(input logic [2:0] c);
        case (c)
            3'h0:    baud_of = 16'd300;
            3'h1:    baud_of = 16'd600;
            3'h2:    baud_of = 16'd1200;
            3'h3:    baud_of = 16'd2400;
            3'h4:    baud_of = 16'd4800;
            3'h5:    baud_of = 16'd9600;
            3'h6:    baud_of = 16'd19200;
            default: baud_of = 16'd38400;
        endcase
    endfunction

    // Validity of a word pair
    function automatic logic words_ok(input logic [15:0] a, input logic [15:0] b);
        logic [4:0] p;
        logic [7:0] s;
        logic       good;
        p    = a[`SPS_W1_PROT_LSB +: 5];
        s    = b[7:0];
        good = !a[15] && !a[11] && !b[`SPS_W2_ZERO_BIT]
            && (b[`SPS_W2_PAR_LSB +: 2] != 2'h1);
        case (p)
            `SPS_PROT_PROG:   good = good && s != 8'h00
                                     && s <= `SPS_ADDR_MAX_NET;
            `SPS_PROT_NET:    good = good && s[6:0] != 7'h00
                                     && {1'b0, s[6:0]} <= `SPS_ADDR_MAX_NET;
            `SPS_PROT_MODBUS: good = good && s != 8'h00
                                     && s <= `SPS_ADDR_MAX_MB;
            `SPS_PROT_ASCII:  good = good && s[7:2] == `SPS_FLOW_PREFIX;
            default:          good = 1'b0;
        endcase
        // Two-wire echo suppression only for MODBUS or ASCII
        if (b[`SPS_W2_ECHO_BIT] && (p == `SPS_PROT_PROG || p == `SPS_PROT_NET)) begin
            good = 1'b0;
        end
        words_ok = good;
    endfunction

    logic        acc;       // APB access phase, answer pending
    logic        fin;       // APB completing edge
    logic        wr;        // Write completes now
    logic        rd;        // Read completes now
    logic        mapped;    // Address decodes
    logic [15:0] rval;      // Read mux
    logic        req;       // Request code written
    logic [1:0]  ev;        // Accepted, error events

    // Next state of everything
    always_comb begin
        n      = r;
        acc    = psel && penable && !r.pready;
        fin    = psel && penable && r.pready;
        wr     = fin && pwrite && !r.pslverr;
        rd     = fin && !pwrite && !r.pslverr;
        req    = wr && paddr == `SPS_OFS_HANDSHAKE
              && pwdata[15:0] == `SPS_CODE_REQUEST;
        ev     = 2'b00;
        mapped = 1'b1;
        rval   = 16'h0000;
        // Read mux and decode
        case (paddr)
            `SPS_OFS_TIMING:     rval = r.w1;
            `SPS_OFS_FRAMING:    rval = r.w2;
            `SPS_OFS_HANDSHAKE:  rval = r.hs;
            `SPS_OFS_BUFPTR:     rval = r.bufp;
            `SPS_OFS_ACT_TIMING: rval = r.act_w1;
            `SPS_OFS_ACT_FRAME:  rval = r.act_w2;
            `SPS_OFS_IRQ_STS:    rval = {14'h0000, r.sts};
            `SPS_OFS_IRQ_MASK:   rval = {14'h0000, r.msk};
            default:             mapped = 1'b0;
        endcase
        // Answer one cycle into the access phase
        n.pready = acc;
        if (acc) begin
            n.prdata  = {16'h0000, rval};
            n.pslverr = !mapped;
        end else if (fin) begin
            n.pslverr = 1'b0;
        end
        // Register writes on the completing edge
        if (wr) begin
            case (paddr)
                `SPS_OFS_TIMING:    n.w1   = pwdata[15:0];
                `SPS_OFS_FRAMING:   n.w2   = pwdata[15:0];
                `SPS_OFS_HANDSHAKE: n.hs   = pwdata[15:0];
                `SPS_OFS_BUFPTR:    n.bufp = pwdata[15:0];
                `SPS_OFS_IRQ_MASK:  n.msk  = pwdata[1:0];
                default:            n.msk  = n.msk;
            endcase
        end
        // Handshake sequencer
        case (r.st)
            SPS_IDLE: begin
                if (req) begin
                    n.st = SPS_CHECK;
                end
            end
            SPS_CHECK: begin
                n.ok = words_ok(r.w1, r.w2);
                n.st = SPS_APPLY;
            end
            SPS_APPLY: begin
                n.st = SPS_IDLE;
                if (r.ok) begin
                    n.hs         = `SPS_CODE_ACCEPT;
                    n.act_w1     = r.w1;
                    n.act_w2     = r.w2;
                    n.autodetect = 1'b0;
                    ev           = 2'b01;
                    if (r.w1[`SPS_W1_PROT_LSB +: 5] == `SPS_PROT_ASCII) begin
                        n.act_buf = r.bufp;
                    end
                end else begin
                    n.hs = `SPS_CODE_ERROR;
                    ev   = 2'b10;
                end
            end
            default: n.st = SPS_IDLE;
        endcase
        // Sticky events, read clears, set wins
        n.sts = ((rd && paddr == `SPS_OFS_IRQ_STS) ? 2'b00 : r.sts) | ev;
        n.irq = |(n.sts & n.msk);
        // Decoded active settings
        n.prot    = r.autodetect ? 5'h00 : r.act_w1[`SPS_W1_PROT_LSB +: 5];
        n.on_ms   = dly_ms(r.act_w1[`SPS_W1_ON_LSB +: 3]);
        n.off_ms  = dly_ms(r.act_w1[`SPS_W1_OFF_LSB +: 3]);
        n.pct     = tmo_pct(r.act_w1[`SPS_W1_TMO_LSB +: 3]);
        n.tmo_ms  = 16'((32'(r.pct) * 32'(`SPS_BASE_TMO_MS)) / 32'd100);
        n.par     = r.act_w2[`SPS_W2_PAR_LSB +: 2];
        n.stop2   = r.act_w2[`SPS_W2_STOP_BIT];
        n.echo    = r.act_w2[`SPS_W2_ECHO_BIT];
        n.baud    = baud_of(r.act_w2[`SPS_W2_BAUD_LSB +: 3]);
        n.fmt     = 1'b0;
        n.flow    = 2'h0;
        n.station = r.act_w2[7:0];
        if (n.prot == `SPS_PROT_NET) begin
            n.fmt     = r.act_w2[`SPS_W2_FMT_BIT];
            n.station = {1'b0, r.act_w2[6:0]};
        end else if (n.prot == `SPS_PROT_ASCII) begin
            n.flow    = r.act_w2[1:0];
            n.station = 8'h00;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r            <= '0;
            r.w1         <= `SPS_RST_TIMING;
            r.w2         <= `SPS_RST_FRAMING;
            r.bufp       <= `SPS_RST_BUFPTR;
            r.act_w1     <= `SPS_RST_TIMING;
            r.act_w2     <= `SPS_RST_FRAMING;
            r.act_buf    <= `SPS_RST_BUFPTR;
            r.autodetect <= 1'b1;
            r.st         <= SPS_IDLE;
            r.pct        <= 13'd100;
            r.tmo_ms     <= `SPS_BASE_TMO_MS;
            r.par        <= 2'h2;
            r.baud       <= 16'd19200;
            r.station    <= 8'h01;
        end else begin
            r <= n;
        end
    end

    // Ports straight from flops
    assign prdata            = r.prdata;
    assign pready            = r.pready;
    assign pslverr           = r.pslverr;
    assign irq               = r.irq;
    assign autodetect        = r.autodetect;
    assign protocol_sel      = r.prot;
    assign rts_on_delay_ms   = r.on_ms;
    assign rts_off_delay_ms  = r.off_ms;
    assign timeout_pct       = r.pct;
    assign timeout_ms        = r.tmo_ms;
    assign parity_code       = r.par;
    assign two_stop_bits     = r.stop2;
    assign echo_suppress     = r.echo;
    assign baud_rate         = r.baud;
    assign station_addr      = r.station;
    assign ascii_format      = r.fmt;
    assign flow_ctrl         = r.flow;
    assign ascii_buffer_addr = r.act_buf;

    // Checks on the handshake and decoded settings
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Request write seen on its completing edge
    sequence s_req;
        req && r.st == SPS_IDLE;
    endsequence
    // Good words present during check
    sequence s_check_good;
        r.st == SPS_CHECK && words_ok(r.w1, r.w2);
    endsequence
    sequence s_check_bad;
        r.st == SPS_CHECK && !words_ok(r.w1, r.w2);
    endsequence

    property p_req_check;
        s_req |=> r.st == SPS_CHECK ##1 r.st == SPS_APPLY ##1 r.st == SPS_IDLE;
    endproperty
    a_req_check: assert property (p_req_check) else $error("request not checked");

    property p_accept;
        s_check_good |-> ##2 (r.hs == `SPS_CODE_ACCEPT && !r.autodetect);
    endproperty
    a_accept: assert property (p_accept) else $error("accept code missing");

    property p_error;
        s_check_bad |-> ##2 r.hs == `SPS_CODE_ERROR;
    endproperty
    a_error: assert property (p_error) else $error("error code missing");

    property p_keep;
        s_check_bad |-> ##1 $stable(r.act_w1) [*2] ##0 $stable(r.act_w2);
    endproperty
    a_keep: assert property (p_keep) else $error("rejected settings applied");

    property p_irq;
        r.st == SPS_APPLY |=> r.sts != 2'b00 ##1 irq == |(r.sts & r.msk);
    endproperty
    a_irq: assert property (p_irq) else $error("event not flagged");

    property p_delay;
        $changed(r.act_w1) |-> ##2 rts_on_delay_ms == dly_ms($past(r.act_w1[14:12], 2));
    endproperty
    a_delay: assert property (p_delay) else $error("RTS delay decode wrong");

    property p_timeout;
        timeout_pct == 13'd100 && $stable(timeout_pct) |=> timeout_ms == 16'd800;
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout wrong");

    property p_auto;
        autodetect |-> protocol_sel == 5'h00 && r.act_w2 == `SPS_RST_FRAMING;
    endproperty
    a_auto: assert property (p_auto) else $error("default lost");

    property p_echo;
        echo_suppress && !autodetect |-> protocol_sel != `SPS_PROT_NET
                                      && protocol_sel != `SPS_PROT_PROG;
    endproperty
    a_echo: assert property (p_echo) else $error("two-wire on bad protocol");

    property p_parity;
        parity_code != 2'h1;
    endproperty
    a_parity: assert property (p_parity) else $error("bad parity applied");
endmodule

// ---- common/sps_map.svh ----
// Purpose: Register offsets, field positions, codes and reset values
// Assumes: APB byte addresses, 32-bit data, 16-bit words in the low half
// Notes:   Definitions only
`ifndef SPS_MAP_SVH
`define SPS_MAP_SVH
// Register byte offsets
`define SPS_OFS_TIMING     12'h000
`define SPS_OFS_FRAMING    12'h004
`define SPS_OFS_HANDSHAKE  12'h008
`define SPS_OFS_BUFPTR     12'h00C
`define SPS_OFS_ACT_TIMING 12'h010
`define SPS_OFS_ACT_FRAME  12'h014
`define SPS_OFS_IRQ_STS    12'h018
`define SPS_OFS_IRQ_MASK   12'h01C
// Handshake codes
`define SPS_CODE_REQUEST   16'h0500
`define SPS_CODE_ACCEPT    16'h0A00
`define SPS_CODE_ERROR     16'h0E00
// Protocol one-hot codes
`define SPS_PROT_PROG      5'h10
`define SPS_PROT_NET       5'h08
`define SPS_PROT_MODBUS    5'h04
`define SPS_PROT_ASCII     5'h02
// Timing word field positions (low bit)
`define SPS_W1_ON_LSB      12
`define SPS_W1_TMO_LSB     8
`define SPS_W1_PROT_LSB    3
`define SPS_W1_OFF_LSB     0
// Framing word field positions (low bit)
`define SPS_W2_PAR_LSB     14
`define SPS_W2_STOP_BIT    13
`define SPS_W2_ZERO_BIT    12
`define SPS_W2_ECHO_BIT    11
`define SPS_W2_BAUD_LSB    8
`define SPS_W2_FMT_BIT     7
// Address limits and flow-control prefix
`define SPS_ADDR_MAX_NET   8'd90
`define SPS_ADDR_MAX_MB    8'd247
`define SPS_FLOW_PREFIX    6'h1C
// Reset values: auto-detect, x1, 0 ms delays, odd, 19200, station 1
`define SPS_RST_TIMING     16'h0000
`define SPS_RST_FRAMING    16'h8601
`define SPS_RST_BUFPTR     16'h0000
// Base timeout in ms
`define SPS_BASE_TMO_MS    16'd800
`endif

// ---- common/sps_pkg.sv ----
// Purpose: Types of the serial port setup register block
// Assumes: Constants come from sps_map.svh
// Notes:   State encoding is Gray along idle, check, apply
package sps_pkg;
    // Handshake sequencer states
    typedef enum logic [1:0] {
        SPS_IDLE  = 2'b00,
        SPS_CHECK = 2'b01,
        SPS_APPLY = 2'b11
    } sps_state_e;
    // All state of the block
    typedef struct packed {
        logic [15:0] w1;
        logic [15:0] w2;
        logic [15:0] hs;
        logic [15:0] bufp;
        logic [15:0] act_w1;
        logic [15:0] act_w2;
        logic [15:0] act_buf;
        logic        autodetect;
        sps_state_e  st;
        logic        ok;
        logic [1:0]  sts;
        logic [1:0]  msk;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        irq;
        logic [4:0]  prot;
        logic [9:0]  on_ms;
        logic [9:0]  off_ms;
        logic [12:0] pct;
        logic [15:0] tmo_ms;
        logic [1:0]  par;
        logic        stop2;
        logic        echo;
        logic [15:0] baud;
        logic [7:0]  station;
        logic        fmt;
        logic [1:0]  flow;
    } sps_state_s;
endpackage

// ---- verif/sps_remote_model.sv ----
// Purpose: Remote serial station that only talks when port settings match its own
// Assumes: Settings arrive decoded from the setup register block
// Notes:   Behavioural; link_ok stands in for a working exchange
`timescale 1ns/100ps
module sps_remote_model #(
    parameter logic [15:0] BAUD    = 16'd19200,
    parameter logic [1:0]  PARITY  = 2'b10,
    parameter logic        STOP2   = 1'b0,
    parameter logic [7:0]  STATION = 8'd23
) (
    input  wire logic        autodetect,
    input  wire logic [15:0] baud_rate,
    input  wire logic [1:0]  parity_code,
    input  wire logic        two_stop_bits,
    input  wire logic [7:0]  station_addr,
    output logic             link_ok
);
    // Framing must agree on both ends, and the port must leave auto-detect
    assign link_ok = !autodetect && baud_rate == BAUD && parity_code == PARITY
                     && two_stop_bits == STOP2 && station_addr == STATION;
endmodule

// ---- verif/tb.sv ----
// Purpose: Self-checking bench for the serial port setup registers
// Assumes: APB answer one cycle into access, outputs settle by W+5
// Notes:   Handshake completion is polled with a bound
`timescale 1ns/100ps
`include "sps_map.svh"
module tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic        autodetect, two_stop_bits, echo_suppress, ascii_format, link_ok, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [4:0]  protocol_sel;
    logic [9:0]  rts_on_delay_ms, rts_off_delay_ms;
    logic [12:0] timeout_pct;
    logic [15:0] timeout_ms, baud_rate, ascii_buffer_addr, res, w1, w2;
    logic [1:0]  parity_code, flow_ctrl;
    logic [7:0]  station_addr;
    int          errors, check_count;
    // Expected lookups per 3-bit code
    int dly_t [8] = '{0, 2, 5, 10, 20, 50, 100, 500};
    int pct_t [8] = '{100, 120, 150, 200, 500, 1000, 2000, 5000};
    int baud_t [8] = '{300, 600, 1200, 2400, 4800, 9600, 19200, 38400};

    sps_setup_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .autodetect(autodetect), .protocol_sel(protocol_sel),
        .rts_on_delay_ms(rts_on_delay_ms), .rts_off_delay_ms(rts_off_delay_ms),
        .timeout_pct(timeout_pct), .timeout_ms(timeout_ms), .parity_code(parity_code),
        .two_stop_bits(two_stop_bits), .echo_suppress(echo_suppress), .baud_rate(baud_rate),
        .station_addr(station_addr), .ascii_format(ascii_format), .flow_ctrl(flow_ctrl),
        .ascii_buffer_addr(ascii_buffer_addr));
    // Far end configured for the worked MODBUS example
    sps_remote_model far_u (.autodetect(autodetect), .baud_rate(baud_rate),
        .parity_code(parity_code), .two_stop_bits(two_stop_bits),
        .station_addr(station_addr), .link_ok(link_ok));

    // Free-running clock, 4 ns period
    always #2 pclk = ~pclk;

    // Verdict and end of run
    task results;
        if (errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Compare seen against expected
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask

    // One APB transfer; held until pready is sampled high
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge pclk);
        end
        if (n == 20) begin
            errors++;
            results();
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Full handshake: words, request code, bounded poll, settle
    task setup(input logic [15:0] a, input logic [15:0] b, input logic [15:0] bp);
        int n;
        n = 0;
        apb(1'b1, `SPS_OFS_TIMING, {16'h0000, a});
        apb(1'b1, `SPS_OFS_FRAMING, {16'h0000, b});
        if (a[7:3] == `SPS_PROT_ASCII) apb(1'b1, `SPS_OFS_BUFPTR, {16'h0000, bp});
        apb(1'b1, `SPS_OFS_HANDSHAKE, {16'h0000, `SPS_CODE_REQUEST});
        do begin
            apb(1'b0, `SPS_OFS_HANDSHAKE, 32'h0);
            n++;
        end while (q[15:0] === `SPS_CODE_REQUEST && n < 10);
        res = q[15:0];
        repeat (3) @(negedge pclk);
    endtask

    // Main sequence
    initial begin
        pclk = 0;
        presetn = 0;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 0;
        pwdata = 0;
        errors = 0;
        check_count = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk("autodetect", autodetect, 1);
        chk("protocol", protocol_sel, 0);
        chk("timeout_ms", timeout_ms, 800);
        chk("pct", timeout_pct, 100);
        chk("rts_on", rts_on_delay_ms, 0);
        chk("rts_off", rts_off_delay_ms, 0);
        chk("defaults", {station_addr, baud_rate, parity_code, two_stop_bits, ascii_format,
            echo_suppress}, {8'd1, 16'd19200, 2'b10, 3'b000});
        apb(1'b0, `SPS_OFS_FRAMING, 0);
        chk("framing reset", q, 32'h8601);
        apb(1'b0, 12'h020, 0);
        chk("unmapped", {err, q}, {1'b1, 32'h0});
        apb(1'b1, `SPS_OFS_IRQ_MASK, 32'h1);
        // Worked MODBUS example: 10 ms on, 5 ms off, odd, 19200, station 23
        setup(16'h3022, 16'h8617, 16'h0);
        chk("result", res, `SPS_CODE_ACCEPT);
        chk("cfg", {protocol_sel, rts_on_delay_ms, rts_off_delay_ms, station_addr},
            {5'h04, 10'd10, 10'd5, 8'd23});
        chk("link", {link_ok, autodetect, irq}, 3'b101);
        apb(1'b0, `SPS_OFS_IRQ_STS, 0);
        chk("sts", q, 1);
        repeat (2) @(negedge pclk);
        chk("irq clr", irq, 0);
        // Bad parity code keeps previous settings, error bit masked off
        setup(16'h3022, 16'h4617, 16'h0);
        chk("result", res, `SPS_CODE_ERROR);
        chk("keep", {station_addr, rts_on_delay_ms, irq}, {8'd23, 10'd10, 1'b0});
        apb(1'b0, `SPS_OFS_IRQ_STS, 0);
        chk("sts", q, 2);
        // Every code of each lookup field, MODBUS with echo and address extremes
        for (int i = 0; i < 8; i++) begin
            w1 = {1'b0, 3'(i), 1'b0, 3'(i), `SPS_PROT_MODBUS, 3'(7 - i)};
            w2 = {i[0] ? 2'b11 : 2'b00, i[1], 1'b0, i[2], 3'(i), i == 7 ? 8'd247 : 8'(i + 1)};
            setup(w1, w2, 16'h0);
            chk("result", res, `SPS_CODE_ACCEPT);
            chk("rts_on", rts_on_delay_ms, dly_t[i]);
            chk("rts_off", rts_off_delay_ms, dly_t[7 - i]);
            chk("pct", timeout_pct, pct_t[i]);
            chk("timeout_ms", timeout_ms, 8 * pct_t[i]);
            chk("baud", baud_rate, baud_t[i]);
            chk("frame", {parity_code, two_stop_bits, echo_suppress},
                {w2[15:13], w2[11]});
            chk("station", station_addr, w2[7:0]);
        end
        // Native protocol: ASCII format, top address, then one beyond
        setup(16'h0040, 16'h86DA, 16'h0);
        chk("net", {res, protocol_sel, ascii_format, station_addr},
            {`SPS_CODE_ACCEPT, 5'h08, 1'b1, 8'd90});
        setup(16'h0040, 16'h86DB, 16'h0);
        chk("net bad", {res, station_addr}, {`SPS_CODE_ERROR, 8'd90});
        setup(16'h0080, 16'h865A, 16'h0);
        chk("prog", {res, protocol_sel}, {`SPS_CODE_ACCEPT, 5'h10});
        // ASCII: each flow-control code and buffer start, then a bad code
        for (int j = 0; j < 4; j++) begin
            setup(16'h0010, 16'h8670 | 16'(j), 16'h2000 + 16'(j));
            chk("ascii", {res, protocol_sel, flow_ctrl},
                {`SPS_CODE_ACCEPT, 5'h02, 2'(j)});
            chk("ascii buffer", ascii_buffer_addr, 16'h2000 + 16'(j));
        end
        setup(16'h0010, 16'h8674, 16'h1234);
        chk("ascii bad", {res, ascii_buffer_addr}, {`SPS_CODE_ERROR, 16'h2003});
        // Mid-run reset brings back the defaults
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk("reset again", {autodetect, protocol_sel, station_addr, ascii_buffer_addr},
            {1'b1, 5'h00, 8'd1, 16'h0000});
        results();
    end

    // Hang guard, well beyond the expected run length
    initial begin
        #200000;
        errors++;
        results();
    end
endmodule
